// ---- common/icsw_pkg.sv ----
// Constants and types shared by the clock switch files.
package icsw_pkg;
    // Register indices on the plain register port.
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_STAT   = 3'h1;
    localparam logic [2:0] ADDR_IRQ    = 3'h2;
    localparam logic [2:0] ADDR_MASK   = 3'h3;
    localparam logic [2:0] ADDR_ACTIVE = 3'h4;
    // Control register fields and reset values.
    localparam int         FREQ_LSB    = 3;
    localparam int         SCS_LSB     = 0;
    localparam logic [3:0] FREQ_RESET  = 4'h7;
    localparam logic [1:0] SCS_RESET   = 2'h0;
    localparam logic [1:0] CFG_INT     = 2'h0;
    // Status register bit positions.
    localparam int         STAT_FAST_RDY = 4;
    localparam int         STAT_SLOW_RDY = 1;
    localparam int         STAT_FAST_STB = 0;
    // Interrupt bits.
    localparam int         IRQ_DONE    = 0;
    localparam int         IRQ_STABLE  = 1;
    localparam int         IRQ_W       = 2;
    // Timing: clock period and the fast oscillator switch time.
    localparam int         CLK_PERIOD_PS   = 8000;
    localparam int         FAST_SWITCH_NS  = 2000;
    localparam int         FAST_SWITCH_CYC = FAST_SWITCH_NS * 1000 / CLK_PERIOD_PS;
    localparam int         WARMUP_CYC_DEF  = 1000;
    localparam logic [1:0] EXT_POR_TICKS   = 2'h2;
    localparam logic [1:0] SWITCH_TICKS    = 2'h1;
    localparam int         TMR_W           = 16;

    typedef enum logic [1:0] {
        SRC_EXT  = 2'h0,
        SRC_FAST = 2'h1,
        SRC_SLOW = 2'h2
    } icsw_src_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_START = 3'h2,
        ST_EDGE  = 3'h4
    } icsw_state_t;

    // Postscaler shift of the fast oscillator for a frequency code.
    function automatic logic [3:0] icsw_div(input logic [3:0] f);
        case (f)
            4'hF: icsw_div = 4'h0;
            4'hE: icsw_div = 4'h1;
            4'hD: icsw_div = 4'h2;
            4'hC: icsw_div = 4'h3;
            4'hB: icsw_div = 4'h4;
            4'hA, 4'h7: icsw_div = 4'h5;
            4'h9, 4'h6: icsw_div = 4'h6;
            4'h8, 4'h5: icsw_div = 4'h7;
            4'h4: icsw_div = 4'h8;
            default: icsw_div = 4'h9;
        endcase
    endfunction : icsw_div
endpackage : icsw_pkg

// ---- common/icsw_tmr_if.sv ----
// Start and done handshake between the switch sequencer and its delay timer.
`timescale 1ns/100ps
`default_nettype none
interface icsw_tmr_if #(parameter int W = 16);
    logic         start;
    logic [W-1:0] count;
    logic         done;
    modport ctl (output start, output count, input done);
    modport tmr (input start, input count, output done);
endinterface : icsw_tmr_if
`default_nettype wire

// ---- rtl/icsw_clk_switch.sv ----
// Internal oscillator frequency selection and system clock source switch.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Frequency codes 1111..1011 give 16 MHz to 1 MHz; 0111..0100, 001x slower.
// R2: Codes 1010, 1001, 1000 give 500, 250, 125 kHz from fast oscillator.
// R3: Codes 000x take the slow 31 kHz oscillator instead of the postscaler.
// R4: Reset loads the frequency field with 0111, 500 kHz.
// R5: Reset clears the source select field to 00.
// R6: Source select 00 uses the configured oscillator source.
// R7: Source select 1x uses the internal block at the selected frequency.
// R8: Reserved source select 01 behaves like 00.
// R9: A stopped new oscillator gets a start-up delay, then a current clock fall.
// R10: Change within the same oscillator skips any start-up delay.
// R11: Status register shows both internal oscillators' present state.
// R12: Status bit 4 is fast ready, bit 1 is slow ready.
// R13: Status bit 0 is fast stable, read only.
// R14: Leaving sleep or reset onto an internal oscillator waits the warm-up delay.
// R15: Switch to fast waits 2 us; to slow, or slow to external, one cycle each.
// R16: Leaving sleep or reset onto the external clock waits two of its cycles.
// R17: Configuration select 11, 10, 01 is external clock, 00 internal oscillator.
module icsw_clk_switch #(
    parameter int WARMUP_CYCLES = icsw_pkg::WARMUP_CYC_DEF
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Register port.
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // Configuration and power state.
    input  wire logic [1:0]  cfg_osc_select,
    input  wire logic        sleep,
    // Oscillator state and clock edge ticks.
    input  wire logic        fast_osc_ready,
    input  wire logic        slow_osc_ready,
    input  wire logic        fast_osc_stable,
    input  wire logic        slow_tick,
    input  wire logic        ext_tick,
    input  wire logic        cur_clk_fall,
    // Clock selection outputs.
    output logic [1:0]       sys_clk_src,
    output logic             sys_clk_valid,
    output logic [3:0]       fast_div_shift,
    output logic             fast_osc_en,
    output logic             slow_osc_en,
    output logic             switch_busy,
    // Interrupt.
    output logic             irq
);
    logic [3:0]                ctrl_freq_reg;
    logic [1:0]                ctrl_scs_reg;
    logic [icsw_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [icsw_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [icsw_pkg::IRQ_W-1:0] irq_event;
    logic                      stable_d_reg;
    icsw_pkg::icsw_state_t     state_reg;
    icsw_pkg::icsw_src_t       act_src_reg;
    icsw_pkg::icsw_src_t       pend_src_reg;
    icsw_pkg::icsw_src_t       tgt_src;
    logic [3:0]                act_freq_reg;
    logic [3:0]                pend_freq_reg;
    logic                      act_valid_reg;
    logic                      use_tmr_reg;
    logic [1:0]                tick_need_reg;
    logic [1:0]                tick_cnt_reg;
    logic                      use_int;
    logic                      change_needed;
    logic                      go;
    logic                      same_src;
    logic                      new_tick;
    logic                      start_over;
    logic                      sw_done;
    logic [icsw_pkg::TMR_W-1:0] start_len_reg;

    icsw_tmr_if #(.W(icsw_pkg::TMR_W)) tmr_if ();

    icsw_delay_timer #(.W(icsw_pkg::TMR_W)) u_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tmr     (tmr_if.tmr)
    );

    // Configured source or internal block selection.
    always_comb begin
        // R17: configuration decode
        use_int = ctrl_scs_reg[1] || (cfg_osc_select == icsw_pkg::CFG_INT);
        // R3: slow oscillator codes
        if (ctrl_freq_reg[3:1] == 3'h0) begin
            tgt_src = icsw_pkg::SRC_SLOW;
        end else begin
            tgt_src = icsw_pkg::SRC_FAST;
        end
        // R6: external when not internal
        if (!use_int) begin
            tgt_src = icsw_pkg::SRC_EXT;
        end
    end

    assign change_needed = !act_valid_reg || (tgt_src != act_src_reg) ||
                           ((tgt_src != icsw_pkg::SRC_EXT) && (ctrl_freq_reg != act_freq_reg));
    assign go        = (state_reg == icsw_pkg::ST_IDLE) && change_needed && !sleep;
    assign same_src  = act_valid_reg && (tgt_src == act_src_reg);
    assign new_tick  = (pend_src_reg == icsw_pkg::SRC_SLOW) ? slow_tick : ext_tick;
    assign start_over = use_tmr_reg ? tmr_if.done : ((tick_cnt_reg + 2'h1) >= tick_need_reg
                                                       && new_tick);
    assign sw_done   = ((state_reg == icsw_pkg::ST_START) && start_over && !act_valid_reg) ||
                       ((state_reg == icsw_pkg::ST_EDGE) && cur_clk_fall);

    // Timer load picks the warm-up or the fast switch delay.
    always_comb begin
        tmr_if.start = 1'b0;
        tmr_if.count = icsw_pkg::TMR_W'(icsw_pkg::FAST_SWITCH_CYC);
        if (go && !same_src) begin
            // R14: warm-up after sleep or reset
            if (!act_valid_reg && tgt_src != icsw_pkg::SRC_EXT) begin
                tmr_if.start = 1'b1;
                tmr_if.count = icsw_pkg::TMR_W'(WARMUP_CYCLES);
            // R15: fast oscillator switch time
            end else if (act_valid_reg && tgt_src == icsw_pkg::SRC_FAST) begin
                tmr_if.start = 1'b1;
            end
        end
    end

    // Switch sequencer.
    always_ff @(posedge clk_sys) begin
        if (!resetn || sleep) begin
            state_reg     <= icsw_pkg::ST_IDLE;
            pend_src_reg  <= icsw_pkg::SRC_EXT;
            pend_freq_reg <= icsw_pkg::FREQ_RESET;
            use_tmr_reg   <= 1'b0;
            tick_need_reg <= icsw_pkg::SWITCH_TICKS;
            tick_cnt_reg  <= 2'h0;
        end else begin
            case (state_reg)
                icsw_pkg::ST_IDLE: begin
                    if (go) begin
                        pend_src_reg  <= tgt_src;
                        pend_freq_reg <= ctrl_freq_reg;
                        use_tmr_reg   <= tmr_if.start;
                        tick_cnt_reg  <= 2'h0;
                        // R16: two external cycles after reset
                        tick_need_reg <= act_valid_reg ? icsw_pkg::SWITCH_TICKS
                                                       : icsw_pkg::EXT_POR_TICKS;
                        // R10: same oscillator goes straight to the edge wait
                        if (same_src) begin
                            state_reg <= icsw_pkg::ST_EDGE;
                        end else begin
                            state_reg <= icsw_pkg::ST_START;
                        end
                    end
                end
                icsw_pkg::ST_START: begin
                    if (!use_tmr_reg && new_tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 2'h1;
                    end
                    // R9: start-up delay then the current clock fall
                    if (start_over) begin
                        state_reg <= act_valid_reg ? icsw_pkg::ST_EDGE : icsw_pkg::ST_IDLE;
                    end
                end
                icsw_pkg::ST_EDGE: begin
                    if (cur_clk_fall) begin
                        state_reg <= icsw_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= icsw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Active selection, updated when a switch completes; sleep clears only its valid flag.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            act_valid_reg  <= 1'b0;
            act_src_reg    <= icsw_pkg::SRC_EXT;
            act_freq_reg   <= icsw_pkg::FREQ_RESET;
            fast_div_shift <= icsw_pkg::icsw_div(icsw_pkg::FREQ_RESET);
        end else if (sleep) begin
            act_valid_reg <= 1'b0;
        end else if (sw_done) begin
            act_valid_reg  <= 1'b1;
            act_src_reg    <= pend_src_reg;
            act_freq_reg   <= pend_freq_reg;
            // R1: postscaler mapping
            // R2: duplicate codes from the fast oscillator
            fast_div_shift <= icsw_pkg::icsw_div(pend_freq_reg);
        end
    end

    assign sys_clk_src   = act_src_reg;
    assign sys_clk_valid = act_valid_reg;
    assign switch_busy   = (state_reg != icsw_pkg::ST_IDLE);
    // R7: internal block oscillators kept running while selected or pending
    assign fast_osc_en = (act_valid_reg && act_src_reg == icsw_pkg::SRC_FAST) ||
                         (switch_busy && pend_src_reg == icsw_pkg::SRC_FAST);
    assign slow_osc_en = (act_valid_reg && act_src_reg == icsw_pkg::SRC_SLOW) ||
                         (switch_busy && pend_src_reg == icsw_pkg::SRC_SLOW);

    // Control register writes.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            // R4: 500 kHz after reset
            ctrl_freq_reg <= icsw_pkg::FREQ_RESET;
            // R5: configured source after reset
            ctrl_scs_reg  <= icsw_pkg::SCS_RESET;
        end else if (reg_wr && reg_addr == icsw_pkg::ADDR_CTRL) begin
            ctrl_freq_reg <= reg_wdata[icsw_pkg::FREQ_LSB +: 4];
            // R8: value 01 is stored but decodes like 00
            ctrl_scs_reg  <= reg_wdata[icsw_pkg::SCS_LSB +: 2];
        end
    end

    // Interrupt status: a new event wins over a write-one clear.
    assign irq_event[icsw_pkg::IRQ_DONE]   = sw_done;
    assign irq_event[icsw_pkg::IRQ_STABLE] = fast_osc_stable && !stable_d_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            stable_d_reg <= 1'b0;
        end else begin
            stable_d_reg <= fast_osc_stable;
            if (reg_wr && reg_addr == icsw_pkg::ADDR_IRQ) begin
                irq_stat_reg <= (irq_stat_reg & ~reg_wdata[icsw_pkg::IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
            if (reg_wr && reg_addr == icsw_pkg::ADDR_MASK) begin
                irq_mask_reg <= reg_wdata[icsw_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                icsw_pkg::ADDR_CTRL:   reg_rdata <= {1'b0, ctrl_freq_reg, 1'b0, ctrl_scs_reg};
                // R11: live oscillator state
                // R12: ready bits
                // R13: stable bit
                icsw_pkg::ADDR_STAT:   reg_rdata <= {3'h0, fast_osc_ready, 2'h0,
                                                     slow_osc_ready, fast_osc_stable};
                icsw_pkg::ADDR_IRQ:    reg_rdata <= {6'h00, irq_stat_reg};
                icsw_pkg::ADDR_MASK:   reg_rdata <= {6'h00, irq_mask_reg};
                icsw_pkg::ADDR_ACTIVE: reg_rdata <= {act_valid_reg, act_freq_reg,
                                                     switch_busy, act_src_reg};
                default:               reg_rdata <= 8'h00;
            endcase
        end
    end

    // Length of the start-up wait, read only by the checks below.
    always_ff @(posedge clk_sys) begin
        if (!resetn || state_reg != icsw_pkg::ST_START) begin
            start_len_reg <= '0;
        end else begin
            start_len_reg <= start_len_reg + 16'h0001;
        end
    end

    // R4: reset frequency
    AST_RESET_FREQ: assert property (@(posedge clk_sys)
        !resetn |=> ctrl_freq_reg == 4'h7) else $error("frequency field not 0111 after reset");
    // R5: reset source select
    AST_RESET_SCS: assert property (@(posedge clk_sys)
        !resetn |=> ctrl_scs_reg == 2'h0) else $error("source select not cleared by reset");
    // R1: top code mapping
    AST_DIV_TOP: assert property (@(posedge clk_sys) disable iff (!resetn)
        sw_done && !sleep && pend_freq_reg == 4'hF |=> fast_div_shift == 4'h0)
        else $error("code 1111 did not select 16 MHz");
    // R2: duplicate code mapping
    AST_DIV_DUP: assert property (@(posedge clk_sys) disable iff (!resetn)
        sw_done && !sleep && pend_freq_reg == 4'hA |=> fast_div_shift == 4'h5)
        else $error("code 1010 did not select 500 kHz");
    // R3: slow oscillator codes
    AST_SLOW_CODE: assert property (@(posedge clk_sys) disable iff (!resetn)
        use_int && ctrl_freq_reg[3:1] == 3'h0 |-> tgt_src == icsw_pkg::SRC_SLOW)
        else $error("code 000x did not pick the slow oscillator");
    // R6: configured external source
    AST_SCS_CFG: assert property (@(posedge clk_sys) disable iff (!resetn)
        !ctrl_scs_reg[1] && cfg_osc_select != 2'h0 |-> tgt_src == icsw_pkg::SRC_EXT)
        else $error("select 0x did not keep the configured source");
    // R7: internal block selection
    AST_SCS_INT: assert property (@(posedge clk_sys) disable iff (!resetn)
        ctrl_scs_reg[1] |-> tgt_src != icsw_pkg::SRC_EXT)
        else $error("select 1x did not pick the internal block");
    // R10: same oscillator skips start-up
    AST_SAME_SRC: assert property (@(posedge clk_sys) disable iff (!resetn)
        go && same_src |=> sleep || state_reg == icsw_pkg::ST_EDGE)
        else $error("same oscillator change waited for start-up");
    // R9: wait for the current clock fall
    AST_EDGE_WAIT: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == icsw_pkg::ST_EDGE && !cur_clk_fall && !sleep
        |=> state_reg == icsw_pkg::ST_EDGE && act_src_reg == $past(act_src_reg))
        else $error("switch completed without a current clock fall");
    // R15: fast switch time
    AST_FAST_WAIT: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == icsw_pkg::ST_START && tmr_if.done && act_valid_reg && !sleep
        |-> start_len_reg == 16'(icsw_pkg::FAST_SWITCH_CYC - 1))
        else $error("fast oscillator switch time wrong");
    // R12: status read data
    AST_STATUS: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && reg_addr == icsw_pkg::ADDR_STAT
        |=> reg_rdata == {3'h0, $past(fast_osc_ready), 2'h0, $past(slow_osc_ready),
                          $past(fast_osc_stable)})
        else $error("status register read wrong");

    COV_SAME: cover property (@(posedge clk_sys) disable iff (!resetn) go && same_src);
    COV_FAST: cover property (@(posedge clk_sys) disable iff (!resetn)
        sw_done && act_valid_reg && pend_src_reg == icsw_pkg::SRC_FAST);
    COV_SLOW: cover property (@(posedge clk_sys) disable iff (!resetn)
        sw_done && pend_src_reg == icsw_pkg::SRC_SLOW);
    COV_IRQ: cover property (@(posedge clk_sys) disable iff (!resetn) irq);
endmodule : icsw_clk_switch
`default_nettype wire

// ---- rtl/icsw_delay_timer.sv ----
// Down counter that reports the end of an oscillator start-up delay.
`timescale 1ns/100ps
`default_nettype none
module icsw_delay_timer #(
    parameter int W = 16
) (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Sequencer side.
    icsw_tmr_if.tmr   tmr
);
    logic [W-1:0] cnt_reg;
    logic         run_reg;

    // Done falls in the last cycle of the loaded count.
    assign tmr.done = run_reg && (cnt_reg == {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            run_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (tmr.start) begin
            run_reg <= 1'b1;
            cnt_reg <= (tmr.count == '0) ? {{(W-1){1'b0}}, 1'b1} : tmr.count;
        end else if (run_reg) begin
            run_reg <= !tmr.done;
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule : icsw_delay_timer
`default_nettype wire

// ---- tb/icsw_osc_model.sv ----
// Oscillator and clock edge model that stands beside the clock switch.
`timescale 1ns/100ps
`default_nettype none
module icsw_osc_model (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Oscillator enables.
    input  wire logic fast_osc_en,
    input  wire logic slow_osc_en,
    // Oscillator state and clock ticks.
    output logic      fast_osc_ready,
    output logic      slow_osc_ready,
    output logic      fast_osc_stable,
    output logic      slow_tick,
    output logic      ext_tick,
    output logic      cur_clk_fall
);
    logic [3:0] fast_age;
    logic [3:0] slow_age;
    logic [7:0] tick_cnt;
    // An oscillator runs a few cycles after its enable and stops at once without it.
    always_ff @(posedge clk_sys) begin
        if (!resetn || !fast_osc_en) fast_age <= 4'h0;
        else if (fast_age != 4'hF) fast_age <= fast_age + 4'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn || !slow_osc_en) slow_age <= 4'h0;
        else if (slow_age != 4'hF) slow_age <= slow_age + 4'h1;
    end
    always_ff @(posedge clk_sys) begin
        tick_cnt <= resetn ? tick_cnt + 8'h01 : 8'h00;
    end
    assign fast_osc_ready  = fast_age >= 4'h3;
    assign fast_osc_stable = fast_age >= 4'h8;
    assign slow_osc_ready  = slow_age >= 4'h2;
    // A stopped slow oscillator makes no ticks.
    assign slow_tick    = slow_osc_ready && tick_cnt[2:0] == 3'h7;
    assign ext_tick     = tick_cnt[1:0] == 2'h1;
    assign cur_clk_fall = tick_cnt[2:0] == 3'h3;
endmodule : icsw_osc_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the clock switch against an oscillator model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    localparam int WARM     = 10;
    localparam int FAST_CYC = 2000 / 8;
    logic       clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val, st_exp;
    logic [1:0] cfg_osc_select = 2'h0, sys_clk_src;
    logic [3:0] fast_div_shift;
    logic       fast_osc_ready, slow_osc_ready, fast_osc_stable, slow_tick, ext_tick;
    logic       cur_clk_fall, sys_clk_valid, fast_osc_en, slow_osc_en, switch_busy, irq;
    logic       was_slow = 1'b0;
    logic [31:0] lfsr = 32'h2C22;
    int         fails = 0, n_compared = 0, cyc = 0, lat;
    int         codes[$] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 1, 2, 0};

    icsw_clk_switch #(.WARMUP_CYCLES(WARM)) i_icsw_clk_switch (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_osc_select(cfg_osc_select),
        .sleep(sleep), .fast_osc_ready(fast_osc_ready), .slow_osc_ready(slow_osc_ready),
        .fast_osc_stable(fast_osc_stable), .slow_tick(slow_tick), .ext_tick(ext_tick),
        .cur_clk_fall(cur_clk_fall), .sys_clk_src(sys_clk_src), .sys_clk_valid(sys_clk_valid),
        .fast_div_shift(fast_div_shift), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
        .switch_busy(switch_busy), .irq(irq));
    icsw_osc_model i_icsw_osc_model (
        .clk_sys(clk_sys), .resetn(resetn), .fast_osc_en(fast_osc_en),
        .slow_osc_en(slow_osc_en), .fast_osc_ready(fast_osc_ready),
        .slow_osc_ready(slow_osc_ready), .fast_osc_stable(fast_osc_stable),
        .slow_tick(slow_tick), .ext_tick(ext_tick), .cur_clk_fall(cur_clk_fall));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected postscaler shift for a fast oscillator frequency code.
    function automatic logic [3:0] exp_shift(input int c);
        if (c >= 8) exp_shift = 4'(15 - c);
        else if (c >= 4) exp_shift = 4'(12 - c);
        else exp_shift = 4'h9;
    endfunction : exp_shift
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // The status snapshot is what the read edge will sample.
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        #1 st_exp = {3'h0, fast_osc_ready, 2'h0, slow_osc_ready, fast_osc_stable};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic count_until(input logic want_irq);
        #1;
        while ((want_irq ? irq : sys_clk_valid) !== 1'b1 && lat < 2000) begin
            @(posedge clk_sys);
            #1 lat++;
        end
        `CHK("event wait", 1'b1, lat < 2000)
    endtask : count_until
    task automatic switch_to(input logic [7:0] ctrl);
        wr(icsw_pkg::ADDR_CTRL, ctrl);
        lat = 1;
        count_until(1'b1);
        `CHK("switch done irq", 1'b1, irq)
        `CHK("busy after done", 1'b0, switch_busy)
        wr(icsw_pkg::ADDR_IRQ, 8'h01);
        #1 `CHK("irq cleared", 1'b0, irq)
    endtask : switch_to
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(icsw_pkg::ADDR_CTRL);
        `CHK("ctrl reset", 8'h38, rd_val)
        `CHK("shift reset", 4'h5, fast_div_shift)
        lat = 2;
        count_until(1'b0);
        `CHK("power-on warm-up", 1'b1, lat >= WARM)
        `CHK("power-on source", icsw_pkg::SRC_FAST, sys_clk_src)
        rd(icsw_pkg::ADDR_ACTIVE);
        `CHK("active selection", 8'hB9, rd_val)
        rd(icsw_pkg::ADDR_IRQ);
        `CHK("done status", 1'b1, rd_val[0])
        `CHK("stable status", 1'b1, rd_val[1])
        `CHK("irq masked", 1'b0, irq)
        wr(icsw_pkg::ADDR_MASK, 8'h01);
        #1 `CHK("irq unmasked", 1'b1, irq)
        wr(icsw_pkg::ADDR_IRQ, 8'h03);
        wr(icsw_pkg::ADDR_STAT, 8'hFF);
        foreach (codes[i]) begin
            switch_to({1'b0, 4'(codes[i]), 3'b010});
            `CHK("source", codes[i] < 2 ? icsw_pkg::SRC_SLOW : icsw_pkg::SRC_FAST, sys_clk_src)
            if (codes[i] >= 2) `CHK("shift", exp_shift(codes[i]), fast_div_shift)
            if (was_slow && codes[i] >= 2) `CHK("to fast wait", 1'b1, lat >= FAST_CYC)
            was_slow = codes[i] < 2;
            rd(icsw_pkg::ADDR_STAT);
            `CHK("status", st_exp, rd_val)
        end
        for (int c = 1; c < 4; c++) begin
            cfg_osc_select <= 2'(c);
            switch_to(8'h39);
            `CHK("reserved select", icsw_pkg::SRC_EXT, sys_clk_src)
            switch_to(8'hFF);
            rd(icsw_pkg::ADDR_CTRL);
            `CHK("ctrl unused bits", 8'h7B, rd_val)
            `CHK("internal 16M", 4'h0, fast_div_shift)
        end
        for (int k = 0; k < 2; k++) begin
            sleep <= 1'b1;
            repeat (3) @(posedge clk_sys);
            #1 `CHK("asleep", 1'b0, sys_clk_valid)
            sleep <= 1'b0;
            lat = 0;
            count_until(1'b0);
            // Two external cycles of the model's four-cycle tick need at least five edges.
            `CHK("wake wait", 1'b1, lat >= (k == 0 ? WARM : 5))
            wr(icsw_pkg::ADDR_IRQ, 8'h03);
            if (k == 0) switch_to(8'h38);
            `CHK("wake source", k == 0 ? icsw_pkg::SRC_EXT : icsw_pkg::SRC_EXT, sys_clk_src)
        end
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            wr(3'(5 + k % 3), lfsr[7:0]);
            rd(3'(5 + k % 3));
            `CHK("unmapped read", 8'h00, rd_val)
        end
        rd(icsw_pkg::ADDR_CTRL);
        `CHK("ctrl kept", 8'h38, rd_val)
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
